// file: logic/citc_top.sv
// cpu interrupt and trap control: flags, vector registers, arbitration
`timescale 1ns/1ps
// Contract
// - twelve sources, four external and eight internal, fixed priority
// - vector_base_high forms upper table byte; resets to zero
// - vector_base_high accessed only by accumulator transfers, not io
// - low table byte is vector_base_low top three bits plus source code
// - vector_base_low at io 33H, trap_control at 34H; low resets zero
// - trap_flag set on undefined opcode; write 0 clears, 1 ignored
// - undefined_byte_position read-only: 0 second byte, 1 third byte
// - three external enables mask inputs; reset gives 001
// - global enable low masks all maskable; enable sets, disable clears both
// - nmi accept copies global into saved then clears global
// - nmi return copies saved into global, saved unchanged
// - reset clears both enable flags
// - maskable accept clears both flags; return_from_interrupt and trap leave them
// - flag-reading loads copy saved enable into parity flag
// - no sampling during enable, disable or flag-reading loads
// - undefined opcode traps regardless of global enable, mode-0 too
// - trap sets flag, pushes pc, restarts at zero
// - no bus release, refresh, dma or wait right after trap state
// - nmi falling-edge latched; acknowledge clears dma enable, vector 0066H
// - ext_irq_0 needs global enable and its own enable; sampled at boundary
module citc_top
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // external pins, active low; internal requests, active high
    input wire logic nmi_n_i,
    input wire logic [2:0] ext_irq_n_i,
    input wire logic [7:0] internal_irq_i,
    // io bus for internal registers
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // sequencer instruction events
    input wire logic instr_boundary_i,
    input wire logic ei_instr_i,
    input wire logic di_instr_i,
    input wire logic return_from_nonmaskable_instr_i,
    input wire logic return_from_interrupt_instr_i,
    input wire logic ld_a_flag_i,
    input wire logic ld_vec_high_i,
    input wire logic [7:0] acc_i,
    input wire logic undef_opcode_i,
    input wire logic undef_third_byte_i,
    input wire logic trap_state_i,
    // answers to the sequencer
    output logic [7:0] vec_high_o,
    output logic parity_flag_o,
    output logic parity_flag_we_o,
    output logic accept_o,
    output logic [3:0] accept_src_o,
    output logic push_pc_o,
    output logic [15:0] restart_addr_o,
    output logic [15:0] table_addr_o,
    output logic table_valid_o,
    output logic dma_disable_o,
    output logic cycle_inhibit_o,
    output logic global_int_enable_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] vec_high;
        logic [7:0] vec_low;
        logic trap_flag;
        logic undef_pos;
        logic [2:0] ext_en;
        logic gie;
        logic sie;
        logic nmi_prev;
        logic nmi_latch;
        logic sample_block;
        logic [7:0] rdata;
        logic pf;
        logic pf_we;
        logic accept;
        logic [3:0] src;
        logic push;
        logic [15:0] restart;
        logic [15:0] table_addr;
        logic table_valid;
        logic dma_dis;
        logic inhibit;
    } citc_state_t;

    citc_state_t cur_ff;
    citc_state_t nxt_cur;
    citc_pick_if pick ();
    logic [11:0] req;
    logic [7:0] trap_ctl_view;
    logic nmi_fall;

    // ------------------------------------------------------------
    // priority picker instance
    // ------------------------------------------------------------
    citc_prio_pick u_pick
    (
        .pick(pick)
    );

    // ------------------------------------------------------------
    // nmi edge and register views
    // ------------------------------------------------------------
    // falling edge of the nmi pin; prev resets high like the idle pin,
    // so no false edge appears right after reset
    assign nmi_fall = cur_ff.nmi_prev & ~nmi_n_i;
    // trap_control as read: flag, byte position, zero gap, three enables
    assign trap_ctl_view = {cur_ff.trap_flag, cur_ff.undef_pos, 3'h0, cur_ff.ext_en};

    // ------------------------------------------------------------
    // request vector
    // ------------------------------------------------------------
    // trap, nmi, then maskable externals and internals;
    // index order is the priority order, lowest index wins.
    // internal line 7 is the trap's slot and never arbitrates,
    // so only seven internal lines reach the picker
    always_comb
    begin
        req[0] = undef_opcode_i;
        req[1] = cur_ff.nmi_latch | nmi_fall;
        req[2] = cur_ff.gie & cur_ff.ext_en[0] & ~ext_irq_n_i[0];
        req[3] = cur_ff.gie & cur_ff.ext_en[1] & ~ext_irq_n_i[1];
        req[4] = cur_ff.gie & cur_ff.ext_en[2] & ~ext_irq_n_i[2];
        req[11:5] = {7{cur_ff.gie}} & internal_irq_i[6:0];
    end
    assign pick.req = req;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one pass decides everything for the next edge:
    // pulses drop first, then io access, then flag instructions,
    // then the trap, then arbitration. later assignments win,
    // so a trap set beats a clearing write in the same cycle
    // and an accepted nmi clears the latch its own edge set.
    // the user must not expect a boundary to be honoured in the
    // cycle of, or right after, an enable, disable or flag load
    always_comb
    begin
        logic boundary;
        logic [4:0] code;
        boundary = 1'b0;
        code = 5'h00;
        nxt_cur = cur_ff;
        nxt_cur.accept = 1'b0;
        nxt_cur.push = 1'b0;
        nxt_cur.table_valid = 1'b0;
        nxt_cur.dma_dis = 1'b0;
        nxt_cur.pf_we = 1'b0;
        // no cycle insertion after trap state
        nxt_cur.inhibit = trap_state_i;
        nxt_cur.nmi_prev = nmi_n_i;
        if (nmi_fall)
        begin
            nxt_cur.nmi_latch = 1'b1;
        end
        nxt_cur.sample_block = ei_instr_i | di_instr_i | ld_a_flag_i;
        // read data is registered and stands until the next read
        // io register reads
        if (io_rd_i && io_addr_i == citc_pkg::VEC_LOW_ADDR)
        begin
            nxt_cur.rdata = cur_ff.vec_low & citc_pkg::VEC_LOW_MASK;
        end
        else if (io_rd_i && io_addr_i == citc_pkg::TRAP_CTL_ADDR)
        begin
            nxt_cur.rdata = trap_ctl_view;
        end
        else if (io_rd_i)
        begin
            nxt_cur.rdata = 8'h00;
        end
        if (io_wr_i && io_addr_i == citc_pkg::VEC_LOW_ADDR)
        begin
            nxt_cur.vec_low = io_wdata_i & citc_pkg::VEC_LOW_MASK;
        end
        else if (io_wr_i && io_addr_i == citc_pkg::TRAP_CTL_ADDR)
        begin
            nxt_cur.ext_en = io_wdata_i[2:0];
            if (!io_wdata_i[citc_pkg::TRAP_FLAG_BIT])
            begin
                nxt_cur.trap_flag = 1'b0;
            end
        end
        if (ld_vec_high_i)
        begin
            nxt_cur.vec_high = acc_i;
        end
        if (ld_a_flag_i)
        begin
            nxt_cur.pf = cur_ff.sie;
            nxt_cur.pf_we = 1'b1;
        end
        if (ei_instr_i)
        begin
            nxt_cur.gie = 1'b1;
            nxt_cur.sie = 1'b1;
        end
        else if (di_instr_i)
        begin
            nxt_cur.gie = 1'b0;
            nxt_cur.sie = 1'b0;
        end
        else if (return_from_nonmaskable_instr_i)
        begin
            nxt_cur.gie = cur_ff.sie;
        end
        // blocking covers the instruction itself and the cycle after,
        // so the saved flag copied to parity is never stale
        // one decision per boundary
        boundary = instr_boundary_i & ~cur_ff.sample_block & ~ei_instr_i & ~di_instr_i & ~ld_a_flag_i;
        // trap preempts, taken even when sampling blocked
        if (undef_opcode_i)
        begin
            nxt_cur.trap_flag = 1'b1;
            nxt_cur.undef_pos = undef_third_byte_i;
            nxt_cur.accept = 1'b1;
            nxt_cur.src = citc_pkg::SRC_TRAP;
            nxt_cur.push = 1'b1;
            nxt_cur.restart = citc_pkg::TRAP_RESTART;
        end
        else if (boundary && pick.any)
        begin
            nxt_cur.accept = 1'b1;
            nxt_cur.src = pick.idx;
            nxt_cur.push = 1'b1;
            if (pick.idx == citc_pkg::SRC_NMI)
            begin
                nxt_cur.sie = cur_ff.gie;
                nxt_cur.gie = 1'b0;
                nxt_cur.nmi_latch = 1'b0;
                nxt_cur.dma_dis = 1'b1;
                nxt_cur.restart = citc_pkg::NMI_RESTART;
            end
            else
            begin
                nxt_cur.gie = 1'b0;
                nxt_cur.sie = 1'b0;
                nxt_cur.restart = citc_pkg::MODE1_RESTART;
                if (pick.idx == citc_pkg::SRC_EXT_IRQ_1)
                begin
                    code = citc_pkg::VEC_CODE_EXT_IRQ_1;
                end
                else if (pick.idx == citc_pkg::SRC_EXT_IRQ_2)
                begin
                    code = citc_pkg::VEC_CODE_EXT_IRQ_2;
                end
                else if (pick.idx != citc_pkg::SRC_EXT_IRQ_0)
                begin
                    code = 5'(citc_pkg::VEC_CODE_INTERNAL0
                        + (5'(pick.idx - citc_pkg::SRC_INTERNAL0) << 1));
                end
                nxt_cur.table_addr = {cur_ff.vec_high, cur_ff.vec_low[7:5], code};
                nxt_cur.table_valid = (pick.idx != citc_pkg::SRC_EXT_IRQ_0);
                // ext_irq_0 data bus modes fetch their vector in the sequencer itself; no table entry
                if (pick.idx == citc_pkg::SRC_EXT_IRQ_0)
                begin
                    nxt_cur.table_addr = {cur_ff.vec_high, 8'h00};
                end
            end
        end
        // return_from_interrupt leaves both flags untouched
        if (return_from_interrupt_instr_i)
        begin
            nxt_cur.gie = nxt_cur.gie;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset: all pulses and flags drop, registers take
    // their reset values, pending nmi edge is forgotten
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            cur_ff <= '0;
            cur_ff.vec_high <= citc_pkg::VEC_HIGH_RST;
            cur_ff.vec_low <= citc_pkg::VEC_LOW_RST;
            cur_ff.ext_en <= citc_pkg::EXT_EN_RST;
            cur_ff.gie <= 1'b0;
            cur_ff.sie <= 1'b0;
            cur_ff.nmi_prev <= 1'b1;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a plain view of the state register,
    // so the sequencer sees no combinational path from its inputs
    assign io_rdata_o = cur_ff.rdata;
    assign vec_high_o = cur_ff.vec_high;
    assign parity_flag_o = cur_ff.pf;
    assign parity_flag_we_o = cur_ff.pf_we;
    assign accept_o = cur_ff.accept;
    assign accept_src_o = cur_ff.src;
    assign push_pc_o = cur_ff.push;
    assign restart_addr_o = cur_ff.restart;
    assign table_addr_o = cur_ff.table_addr;
    assign table_valid_o = cur_ff.table_valid;
    assign dma_disable_o = cur_ff.dma_dis;
    assign cycle_inhibit_o = cur_ff.inhibit;
    assign global_int_enable_o = cur_ff.gie;
endmodule // citc_top

// file: common/citc_pkg.sv
// package: constants and types for the cpu interrupt and trap control block
package citc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_LOW_ADDR = 8'h33;
    localparam logic [7:0] TRAP_CTL_ADDR = 8'h34;
    localparam logic [7:0] VEC_HIGH_RST = 8'h00;
    localparam logic [7:0] VEC_LOW_RST = 8'h00;
    localparam int TRAP_FLAG_BIT = 7;
    localparam int UNDEF_POS_BIT = 6;
    localparam logic [2:0] EXT_EN_RST = 3'h1;
    localparam logic [7:0] VEC_LOW_MASK = 8'hE0;
    // ------------------------------------------------------------
    // restart addresses
    // ------------------------------------------------------------
    localparam logic [15:0] NMI_RESTART = 16'h0066;
    localparam logic [15:0] TRAP_RESTART = 16'h0000;
    localparam logic [15:0] MODE1_RESTART = 16'h0038;
    // ------------------------------------------------------------
    // sources, highest priority first
    // ------------------------------------------------------------
    localparam int NUM_SRC = 12;
    localparam int NUM_INTERNAL = 8;
    typedef enum logic [3:0]
    {
        SRC_TRAP = 4'h0,
        SRC_NMI = 4'h1,
        SRC_EXT_IRQ_0 = 4'h2,
        SRC_EXT_IRQ_1 = 4'h3,
        SRC_EXT_IRQ_2 = 4'h4,
        SRC_INTERNAL0 = 4'h5,
        SRC_NONE = 4'hF
    } citc_src_t;
    // five-bit low vector codes for ext_irq_1, ext_irq_2 and internal sources 0..6
    localparam logic [4:0] VEC_CODE_EXT_IRQ_1 = 5'h00;
    localparam logic [4:0] VEC_CODE_EXT_IRQ_2 = 5'h02;
    localparam logic [4:0] VEC_CODE_INTERNAL0 = 5'h04;
    localparam logic [4:0] VEC_CODE_STEP = 5'h02;
endpackage

// file: common/citc_pick_if.sv
// interface: request vector into the priority picker and its choice
`timescale 1ns/1ps
interface citc_pick_if;
    logic [11:0] req;
    logic [3:0] idx;
    logic any;
    modport picker
    (
        input req,
        output idx,
        output any
    );
    modport user
    (
        output req,
        input idx,
        input any
    );
endinterface

// file: logic/citc_prio_pick.sv
// fixed priority picker: lowest index wins
`timescale 1ns/1ps
module citc_prio_pick
(
    citc_pick_if.picker pick
);
    // ------------------------------------------------------------
    // search from the top index down so the lowest set index remains
    // ------------------------------------------------------------
    always_comb
    begin
        pick.idx = 4'hF;
        pick.any = 1'b0;
        for (int k = citc_pkg::NUM_SRC - 1; k >= 0; k--)
        begin
            if (pick.req[k])
            begin
                pick.idx = 4'(k);
                pick.any = 1'b1;
            end
        end
    end
endmodule // citc_prio_pick

// file: test/citc_checker.sv
// checker: timing relations at the ports of the interrupt and trap block
`timescale 1ns/1ps
module citc_checker
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic instr_boundary_i,
    input wire logic ei_instr_i,
    input wire logic di_instr_i,
    input wire logic ld_a_flag_i,
    input wire logic undef_opcode_i,
    input wire logic trap_state_i,
    input wire logic parity_flag_we_o,
    input wire logic accept_o,
    input wire logic [3:0] accept_src_o,
    input wire logic push_pc_o,
    input wire logic [15:0] restart_addr_o,
    input wire logic dma_disable_o,
    input wire logic cycle_inhibit_o,
    input wire logic global_int_enable_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // -------------------------------------------------
    // assertions
    // -------------------------------------------------
    // enable sets flag
    property p_ei;
        ei_instr_i && !di_instr_i |=> global_int_enable_o;
    endproperty
    a_ei: assert property (p_ei) else $error("enable flag not set");
    property p_di;
        di_instr_i |=> !global_int_enable_o;
    endproperty
    a_di: assert property (p_di) else $error("enable flag not cleared");
    property p_nmi;
        accept_o && accept_src_o == 4'h1 |-> restart_addr_o == 16'h0066 && dma_disable_o && !global_int_enable_o;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi accept wrong");
    property p_trap;
        undef_opcode_i |=> accept_o && push_pc_o && accept_src_o == 4'h0 && restart_addr_o == 16'h0000;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken");
    property p_inhibit;
        trap_state_i |=> cycle_inhibit_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("no inhibit after trap state");
    property p_masked;
        accept_o && !$past(global_int_enable_o) |-> accept_src_o <= 4'h1;
    endproperty
    a_masked: assert property (p_masked) else $error("maskable taken while disabled");
    property p_ldflag;
        ld_a_flag_i |=> parity_flag_we_o && global_int_enable_o == $past(global_int_enable_o);
    endproperty
    a_ldflag: assert property (p_ldflag) else $error("flag load wrong");
    property p_no_sample;
        (ei_instr_i || di_instr_i || ld_a_flag_i) && instr_boundary_i && !undef_opcode_i |=> !accept_o;
    endproperty
    a_no_sample: assert property (p_no_sample) else $error("request sampled too early");
endmodule // citc_checker

// file: test/citc_req_model.sv
// model of the external and on-chip interrupt requesters
`timescale 1ns/1ps
module citc_req_model
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] raise_i,
    input wire logic accept_i,
    input wire logic [3:0] src_i,
    output logic nmi_n_o,
    output logic [2:0] ext_irq_n_o,
    output logic [7:0] internal_irq_o
);
    logic [11:0] pend_ff;
    logic [11:0] ack;
    // acknowledge of one source; raise bit 0 withdraws all
    assign ack = accept_i ? (12'h001 << src_i) : 12'h000;
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || raise_i[0])
            pend_ff <= 12'h000;
        else
            pend_ff <= (pend_ff | raise_i) & ~ack;
    end
    // nmi falls once, rises after acknowledge
    assign nmi_n_o = ~pend_ff[1];
    assign ext_irq_n_o = ~pend_ff[4:2];
    assign internal_irq_o = {1'b0, pend_ff[11:5]};
endmodule // citc_req_model

// file: test/tb_cpu_interrupt_trap_control.sv
// self-checking bench for the interrupt and trap control block
`timescale 1ns/1ps
module tb_cpu_interrupt_trap_control;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [11:0] raise = 12'h000;
    logic [7:0] io_addr = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] acc = 8'h00;
    logic third = 1'b0;
    logic trap_st = 1'b0;
    logic nmi_n, par, par_we, accept, push, tvalid, dma, inhib, gie;
    logic [2:0] ext_n;
    logic [7:0] irq, rdata, vhigh;
    logic [3:0] src;
    logic [15:0] restart, taddr;
    int n_fail = 0;
    int checked = 0;
    // events: boundary ei di return_from_nonmaskable return_from_interrupt ld_flag ld_vec undef
    citc_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .nmi_n_i(nmi_n), .ext_irq_n_i(ext_n),
        .internal_irq_i(irq), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
        .io_rdata_o(rdata), .instr_boundary_i(ev[0]), .ei_instr_i(ev[1]), .di_instr_i(ev[2]),
        .return_from_nonmaskable_instr_i(ev[3]), .return_from_interrupt_instr_i(ev[4]), .ld_a_flag_i(ev[5]), .ld_vec_high_i(ev[6]),
        .acc_i(acc), .undef_opcode_i(ev[7]), .undef_third_byte_i(third), .trap_state_i(trap_st),
        .vec_high_o(vhigh), .parity_flag_o(par), .parity_flag_we_o(par_we), .accept_o(accept),
        .accept_src_o(src), .push_pc_o(push), .restart_addr_o(restart), .table_addr_o(taddr),
        .table_valid_o(tvalid), .dma_disable_o(dma), .cycle_inhibit_o(inhib), .global_int_enable_o(gie));
    citc_req_model req_m (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .raise_i(raise), .accept_i(accept),
        .src_i(src), .nmi_n_o(nmi_n), .ext_irq_n_o(ext_n), .internal_irq_o(irq));
    // clock
    always #5 ref_clk_i = ~ref_clk_i;
    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [7:0] e);
        ev = e;
        tick();
        ev = 8'h00;
    endtask
    task automatic req(input logic [11:0] r);
        raise = r;
        tick();
        raise = 12'h000;
    endtask
    task automatic io_w(input logic [7:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        tick();
        io_wr = 1'b0;
    endtask
    task automatic io_r(input logic [7:0] a);
        io_addr = a;
        io_rd = 1'b1;
        tick();
        io_rd = 1'b0;
    endtask
    task automatic take(input logic [3:0] s, input logic [15:0] a);
        fire(8'h01);
        cmp({accept, push, src}, {2'b11, s});
        cmp(tvalid ? taddr : restart, a);
    endtask
    task automatic end_sim;
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // -------------------------------------------------
    // scenarios
    // -------------------------------------------------
    task automatic t_regs;
        io_r(8'h33);
        cmp(rdata, 8'h00);
        io_r(8'h34);
        cmp(rdata, 8'h01);
        io_r(8'h35);
        cmp({rdata, vhigh}, 16'h0000);
        cmp(gie, 1'b0);
        io_w(8'h33, 8'hFF);
        io_r(8'h33);
        cmp(rdata, 8'hE0);
        io_w(8'h34, 8'hFF);
        io_r(8'h34);
        cmp(rdata, 8'h07);
        acc = 8'hA5;
        fire(8'h40);
        cmp(vhigh, 8'hA5);
    endtask
    task automatic t_mask;
        req(12'h008);
        fire(8'h01);
        cmp(accept, 1'b0);
        fire(8'h03);
        cmp({accept, gie}, 2'b01);
        tick();
        take(4'h3, 16'hA5E0);
        cmp(gie, 1'b0);
    endtask
    task automatic t_all;
        for (int s = 2; s < 12; s++)
        begin
            fire(8'h02);
            req(12'h001 << s);
            take(s[3:0], s == 2 ? 16'h0038 : s == 3 ? 16'hA5E0 : s == 4 ? 16'hA5E2 : 16'hA5E4 + 2 * (s - 5));
        end
        fire(8'h02);
        req(12'hFFC);
        take(4'h2, 16'h0038);
        req(12'h001);
    endtask
    task automatic t_ext_mask;
        io_w(8'h34, 8'h00);
        fire(8'h02);
        req(12'h004);
        fire(8'h01);
        cmp(accept, 1'b0);
        io_w(8'h34, 8'h01);
        take(4'h2, 16'h0038);
    endtask
    task automatic t_nmi;
        fire(8'h02);
        req(12'h002);
        take(4'h1, 16'h0066);
        cmp({dma, gie}, 2'b10);
        fire(8'h08);
        cmp(gie, 1'b1);
        fire(8'h20);
        cmp({par_we, par}, 2'b11);
        fire(8'h04);
        fire(8'h20);
        cmp(par, 1'b0);
        req(12'h002);
        take(4'h1, 16'h0066);
        fire(8'h08);
        cmp(gie, 1'b0);
        fire(8'h02);
        fire(8'h10);
        cmp(gie, 1'b1);
    endtask
    task automatic t_trap;
        req(12'h002);
        third = 1'b1;
        fire(8'h81);
        third = 1'b0;
        cmp({accept, push, src, gie}, 7'h61);
        cmp(restart, 16'h0000);
        io_r(8'h34);
        cmp(rdata, 8'hC1);
        io_w(8'h34, 8'h01);
        io_r(8'h34);
        cmp(rdata & 8'h80, 8'h00);
        trap_st = 1'b1;
        tick();
        trap_st = 1'b0;
        cmp(inhib, 1'b1);
        take(4'h1, 16'h0066);
        fire(8'h80);
        cmp({accept, push, src}, 6'h30);
        io_r(8'h34);
        cmp(rdata, 8'h81);
    endtask
    task automatic t_reset;
        fire(8'h02);
        io_w(8'h34, 8'h07);
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        cmp(gie, 1'b0);
        fire(8'h20);
        cmp({par_we, par}, 2'b10);
        io_r(8'h34);
        cmp(rdata, 8'h01);
        cmp(vhigh, 8'h00);
    endtask
    // -------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------
    initial
    begin
        tick(20);
        sys_rst_i = 1'b0;
        t_regs();
        t_mask();
        t_all();
        t_ext_mask();
        t_nmi();
        t_trap();
        t_reset();
        end_sim();
    end
    initial
    begin
        #50000;
        n_fail++;
        end_sim();
    end
endmodule // tb_cpu_interrupt_trap_control
bind citc_top citc_checker chk (.*);
